// ---- core/cfg_rst_consts.svh ----
// Offsets, field positions, reset values and timing counts of the config/reset register bank
`ifndef CFG_RST_CONSTS_SVH
`define CFG_RST_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_BUS_ADDRESS_SELECT      8'h00
`define OFS_SOFT_RESET_CONTROL      8'h01
`define OFS_OUTPUT_BEHAVIOUR_CONFIG 8'h02
`define OFS_BIST_OSC_FREQ           8'h24

// ****************************************
// Field positions
// ****************************************
`define BIT_ADDRESS_SOURCE_SELECT   0
`define BIT_LOGIC_ONLY_SOFT_RESET   0
`define BIT_FULL_SOFT_RESET         1
`define RST_STORED_LSB              2
`define BIT_OUT_ENABLE              7
`define BIT_OUT_OVERRIDE            6
`define BIT_FALLBACK_OSC_CLOCK_ON   5
`define BIT_UNLOCKED_STATE_CHOICE   4
`define OSC_FREQ_LSB                1
`define OSC_FREQ_MSB                2

// ****************************************
// Reset values
// ****************************************
`define RST_SOFT_RESET_CONTROL      8'h04
`define RST_OUTPUT_BEHAVIOUR_CONFIG 8'h80
`define RST_OSC_FREQ_REG            8'h00

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_PS               8000
`define LOGIC_RESET_PULSE_CYC       16'h0010
`define FULL_RESET_PULSE_CYC        16'h0010

`endif

// ---- core/cfg_rst_pkg.sv ----
// Types shared by the config/reset register bank
package cfg_rst_pkg;
   typedef enum logic [2:0] {
      RST_IDLE  = 3'b001,
      RST_LOGIC = 3'b010,
      RST_FULL  = 3'b100
   } soft_rst_state_t;
endpackage

// ---- core/reset_pulse_timer.sv ----
// Counter that stretches a soft reset request into a timed pulse
`timescale 1ns/1ps
`include "cfg_rst_consts.svh"
module reset_pulse_timer #(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Control
   input  wire logic             start_i,
   input  wire logic [CNT_W-1:0] length_i,
   // Status
   output logic                  busy_o,
   output logic                  done_o
);
   logic [CNT_W-1:0] count_r;

   // Load on start, count down to zero, and flag done for one cycle on the step from one
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         count_r <= '0;
         done_o  <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (start_i && count_r == '0) begin
            count_r <= length_i;
         end else if (count_r != '0) begin
            count_r <= count_r - 1'b1;
            done_o  <= (count_r == {{(CNT_W-1){1'b0}}, 1'b1});
         end
      end
   end

   assign busy_o = (count_r != '0);
endmodule

// ---- core/cfg_rst_regs.sv ----
// Address select, soft reset and unlocked-output control registers of the deserializer
// How it works
// - Address register bits 7:1 hold the 7-bit bus address, strap value at start-up.
// - Address bit 0 picks strap address (0) or programmed address (1).
// - Writing reset bit 1 resets whole core with registers; bit self-clears.
// - Full soft reset reloads strap-sourced registers with their original strap value.
// - Writing reset bit 0 resets core logic but keeps registers; bit self-clears.
// - Config bit 6 makes programmed enable and sleep-state values take effect.
// - Without override the effective output enable is forced to 1.
// - Config bit 5 puts the oscillator clock on the pixel clock when unlocked.
// - Fallback oscillator frequency comes from a field of register 0x24.
// - Bit 4 sets output state while lock is low, together with output enable.
// - Without override the effective sleep-state select is forced to 1.
`timescale 1ns/1ps
`include "cfg_rst_consts.svh"
module cfg_rst_regs
   import cfg_rst_pkg::*;
#(
   parameter int          CNT_W          = 16,
   parameter logic [15:0] LOGIC_RST_CYC  = `LOGIC_RESET_PULSE_CYC,
   parameter logic [15:0] FULL_RST_CYC   = `FULL_RESET_PULSE_CYC
) (
   // Clock and reset
   input  wire logic       CLK_I,
   input  wire logic       SYS_RST_I,
   // Register port from the control bus slave
   input  wire logic [7:0] REG_ADDR_I,
   input  wire logic [7:0] REG_WDATA_I,
   input  wire logic       REG_WR_I,
   input  wire logic       REG_RD_I,
   output logic [7:0]      REG_RDATA_O,
   // Strap and link status pins
   input  wire logic [6:0] ADDRESS_STRAP_PIN_I,
   input  wire logic       LINK_LOCK_I,
   // Clocks for the pixel clock pin
   input  wire logic       RECOVERED_PCLK_I,
   input  wire logic       OSC_CLK_I,
   // Effective controls to the core
   output logic [6:0]      BUS_ADDRESS_O,
   output logic            CORE_LOGIC_RST_O,
   output logic            CORE_FULL_RST_O,
   output logic            OUT_ENABLE_O,
   output logic            UNLOCKED_STATE_CHOICE_O,
   output logic            OUTPUTS_ACTIVE_O,
   output logic            PCLK_USE_OSC_O,
   output logic            PCLK_O,
   output logic [1:0]      OSC_FREQ_SEL_O
);
   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [6:0] strap_s1_r;
   logic [6:0] strap_s2_r;
   logic       lock_s1_r;
   logic       lock_s2_r;

   // Strap and lock are asynchronous pins; two flops before any use
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         strap_s1_r <= '0;
         strap_s2_r <= '0;
         lock_s1_r  <= 1'b0;
         lock_s2_r  <= 1'b0;
      end else begin
         strap_s1_r <= ADDRESS_STRAP_PIN_I;
         strap_s2_r <= strap_s1_r;
         lock_s1_r  <= LINK_LOCK_I;
         lock_s2_r  <= lock_s1_r;
      end
   end

   // ****************************************
   // Soft reset sequencer
   // ****************************************
   soft_rst_state_t state_r;
   soft_rst_state_t state_nxt;
   logic            tmr_start;
   logic [CNT_W-1:0] tmr_len;
   logic            tmr_busy;
   logic            tmr_done;
   logic            wr_rst_reg;
   logic [2:0]      strap_load_r;

   assign wr_rst_reg = REG_WR_I && (REG_ADDR_I == `OFS_SOFT_RESET_CONTROL);

   // Full reset wins when both bits are written at once
   always_comb begin
      state_nxt = state_r;
      tmr_start = 1'b0;
      tmr_len   = CNT_W'(LOGIC_RST_CYC);
      case (state_r)
         RST_IDLE: begin
            if (wr_rst_reg && REG_WDATA_I[`BIT_FULL_SOFT_RESET]) begin
               state_nxt = RST_FULL;
               tmr_start = 1'b1;
               tmr_len   = CNT_W'(FULL_RST_CYC);
            end else if (wr_rst_reg && REG_WDATA_I[`BIT_LOGIC_ONLY_SOFT_RESET]) begin
               state_nxt = RST_LOGIC;
               tmr_start = 1'b1;
            end
         end
         RST_LOGIC: begin
            if (tmr_done) begin
               state_nxt = RST_IDLE;
            end
         end
         RST_FULL: begin
            if (tmr_done) begin
               state_nxt = RST_IDLE;
            end
         end
         default: begin
            state_nxt = RST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         state_r <= RST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   reset_pulse_timer #(
      .CNT_W    (CNT_W)
   ) u_timer (
      .clk_i    (CLK_I),
      .rst_i    (SYS_RST_I),
      .start_i  (tmr_start),
      .length_i (tmr_len),
      .busy_o   (tmr_busy),
      .done_o   (tmr_done)
   );

   // Core resets are held for the whole timed window
   assign CORE_LOGIC_RST_O = (state_r != RST_IDLE);
   assign CORE_FULL_RST_O  = (state_r == RST_FULL);

   // ****************************************
   // Register storage
   // ****************************************
   logic [6:0] bus_address_field_r;
   logic       address_source_select_r;
   logic [5:0] rst_upper_r;
   logic [7:0] out_cfg_r;
   logic [7:0] osc_reg_r;
   logic       wr_addr_reg;
   logic       wr_cfg_reg;
   logic       wr_osc_reg;

   assign wr_addr_reg = REG_WR_I && (REG_ADDR_I == `OFS_BUS_ADDRESS_SELECT);
   assign wr_cfg_reg  = REG_WR_I && (REG_ADDR_I == `OFS_OUTPUT_BEHAVIOUR_CONFIG);
   assign wr_osc_reg  = REG_WR_I && (REG_ADDR_I == `OFS_BIST_OSC_FREQ);

   // Synchroniser output carries the strap only two edges after release,
   // so the load window stays open for three edges after a system or full reset
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         strap_load_r <= 3'b111;
      end else begin
         strap_load_r <= {strap_load_r[1:0], CORE_FULL_RST_O};
      end
   end

   // Address register; strap reload wins over any write
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         bus_address_field_r     <= '0;
         address_source_select_r <= 1'b0;
      end else if (strap_load_r[2] || CORE_FULL_RST_O) begin
         bus_address_field_r     <= strap_s2_r;
         address_source_select_r <= 1'b0;
      end else if (wr_addr_reg) begin
         bus_address_field_r     <= REG_WDATA_I[7:1];
         address_source_select_r <= REG_WDATA_I[`BIT_ADDRESS_SOURCE_SELECT];
      end
   end

   // Other registers return to defaults on full soft reset; writes ignored meanwhile
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         rst_upper_r <= 6'(`RST_SOFT_RESET_CONTROL >> `RST_STORED_LSB);
         out_cfg_r   <= `RST_OUTPUT_BEHAVIOUR_CONFIG;
         osc_reg_r   <= `RST_OSC_FREQ_REG;
      end else if (CORE_FULL_RST_O) begin
         rst_upper_r <= 6'(`RST_SOFT_RESET_CONTROL >> `RST_STORED_LSB);
         out_cfg_r   <= `RST_OUTPUT_BEHAVIOUR_CONFIG;
         osc_reg_r   <= `RST_OSC_FREQ_REG;
      end else begin
         if (wr_rst_reg) begin
            rst_upper_r <= REG_WDATA_I[7:`RST_STORED_LSB];
         end
         if (wr_cfg_reg) begin
            out_cfg_r <= REG_WDATA_I;
         end
         if (wr_osc_reg) begin
            osc_reg_r <= REG_WDATA_I;
         end
      end
   end

   // ****************************************
   // Effective controls
   // ****************************************
   logic override;

   assign override = out_cfg_r[`BIT_OUT_OVERRIDE];
   // Programmed address only once selected, strap otherwise
   assign BUS_ADDRESS_O = address_source_select_r ? bus_address_field_r : strap_s2_r;
   assign OUT_ENABLE_O  = override ? out_cfg_r[`BIT_OUT_ENABLE] : 1'b1;
   assign UNLOCKED_STATE_CHOICE_O = override ? out_cfg_r[`BIT_UNLOCKED_STATE_CHOICE]
                                             : 1'b1;
   // Outputs need the enable; when locked they run, while unlocked the sleep choice decides
   assign OUTPUTS_ACTIVE_O = OUT_ENABLE_O
                           && (lock_s2_r || !UNLOCKED_STATE_CHOICE_O);
   assign PCLK_USE_OSC_O = out_cfg_r[`BIT_FALLBACK_OSC_CLOCK_ON] && !lock_s2_r;
   assign OSC_FREQ_SEL_O = osc_reg_r[`OSC_FREQ_MSB:`OSC_FREQ_LSB];
   // Clock mux only; glitch-free switching is left to the pad cell
   assign PCLK_O = PCLK_USE_OSC_O ? OSC_CLK_I : RECOVERED_PCLK_I;

   // ****************************************
   // Read data
   // ****************************************
   logic [7:0] rdata_nxt;

   // Reset bits 1:0 show the live sequencer, so they read 0 once done
   always_comb begin
      if (REG_ADDR_I == `OFS_BUS_ADDRESS_SELECT) begin
         rdata_nxt = {bus_address_field_r, address_source_select_r};
      end else if (REG_ADDR_I == `OFS_SOFT_RESET_CONTROL) begin
         rdata_nxt = {rst_upper_r, state_r == RST_FULL, state_r == RST_LOGIC};
      end else if (REG_ADDR_I == `OFS_OUTPUT_BEHAVIOUR_CONFIG) begin
         rdata_nxt = {out_cfg_r[7:4], 4'h0};
      end else if (REG_ADDR_I == `OFS_BIST_OSC_FREQ) begin
         rdata_nxt = osc_reg_r;
      end else begin
         rdata_nxt = 8'h00;
      end
   end

   // Captured on the strobe and held until the next read
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         REG_RDATA_O <= 8'h00;
      end else if (REG_RD_I) begin
         REG_RDATA_O <= rdata_nxt;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   // Effective controls, sequencer timing and register behaviour under soft reset
   AST_DEFAULT_OE: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      !out_cfg_r[`BIT_OUT_OVERRIDE] |-> OUT_ENABLE_O)
      else $error("output enable not forced high without override");
   AST_DEFAULT_OSS: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      !override |-> UNLOCKED_STATE_CHOICE_O)
      else $error("sleep select not forced high without override");
   AST_OVR_OE: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      override |-> OUT_ENABLE_O == out_cfg_r[`BIT_OUT_ENABLE])
      else $error("override value not applied");
   AST_ADDR_SRC: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      !address_source_select_r |-> BUS_ADDRESS_O == strap_s2_r)
      else $error("strap address not used");
   AST_OSC_PCLK: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      (out_cfg_r[`BIT_FALLBACK_OSC_CLOCK_ON] && !lock_s2_r) |-> PCLK_USE_OSC_O)
      else $error("oscillator clock not selected on unlock");
   AST_LOGIC_RST: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      (state_r == RST_IDLE && wr_rst_reg && !REG_WDATA_I[`BIT_FULL_SOFT_RESET]
       && REG_WDATA_I[`BIT_LOGIC_ONLY_SOFT_RESET])
      |=> CORE_LOGIC_RST_O && !CORE_FULL_RST_O)
      else $error("logic-only reset not started");
   AST_FULL_RST: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      (state_r == RST_IDLE && wr_rst_reg && REG_WDATA_I[`BIT_FULL_SOFT_RESET])
      |=> CORE_FULL_RST_O)
      else $error("full reset not started");
   AST_SELF_CLEAR: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      $rose(CORE_LOGIC_RST_O) |-> ##[1:40] !CORE_LOGIC_RST_O)
      else $error("soft reset bit did not clear");
   AST_STRAP_RELOAD: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      $fell(CORE_FULL_RST_O) |=> bus_address_field_r == $past(strap_s2_r)
                                 && !address_source_select_r)
      else $error("strap not reloaded");
   AST_TMR_BUSY: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      (state_r != RST_IDLE) |-> (tmr_busy || tmr_done))
      else $error("soft reset state without a running timer");
   AST_RST_HOLD: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      (state_r != RST_IDLE && !tmr_done) |=> state_r == $past(state_r))
      else $error("soft reset left or restarted before its timer ended");
   AST_FULL_REGS: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      CORE_FULL_RST_O |=> out_cfg_r == `RST_OUTPUT_BEHAVIOUR_CONFIG)
      else $error("config register not held at default during full reset");
   AST_RD_CLEAR: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      (state_r == RST_IDLE && REG_RD_I && REG_ADDR_I == `OFS_SOFT_RESET_CONTROL)
      |=> !REG_RDATA_O[`BIT_FULL_SOFT_RESET] && !REG_RDATA_O[`BIT_LOGIC_ONLY_SOFT_RESET])
      else $error("self-clearing reset bit reads back set");
endmodule

// ---- sim/cfg_host_model.sv ----
// Host controller model that programs the config and reset registers
`timescale 1ns/1ps
`include "cfg_rst_consts.svh"
module cfg_host_model #(
   parameter int WAIT_CYC = 62500
) (
   // Clock
   input  wire logic       clk_i,
   // Register port towards the bank
   output logic [7:0]      addr_o,
   output logic [7:0]      wdata_o,
   output logic            wr_o,
   output logic            rd_o,
   input  wire logic [7:0] rdata_i
);
   logic oe_last;

   // Idle bus before the first request
   initial begin
      addr_o  = 8'h00;
      wdata_o = 8'h00;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
      oe_last = 1'b1;
   end

   // One write; address and data flip after release so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      addr_o  = a;
      wdata_o = d;
      wr_o    = 1'b1;
      @(negedge clk_i);
      wr_o    = 1'b0;
      addr_o  = ~a;
      wdata_o = ~d;
   endtask

   // One read; data is registered, so it is picked up a cycle later
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_i);
      addr_o = a;
      rd_o   = 1'b1;
      @(negedge clk_i);
      rd_o   = 1'b0;
      addr_o = ~a;
      @(negedge clk_i);
      d = rdata_i;
   endtask

   // Register-keeping reset, then the settle time before anything else
   task automatic logic_reset();
      wr(`OFS_SOFT_RESET_CONTROL, 8'h01);
      repeat (WAIT_CYC) @(negedge clk_i);
   endtask

   // Full reset; the stored enable bit returns to its reset value 1
   task automatic full_reset();
      wr(`OFS_SOFT_RESET_CONTROL, 8'h02);
      repeat (WAIT_CYC) @(negedge clk_i);
      oe_last = 1'b1;
   endtask

   // Config write; an enable rise is always followed by a logic reset
   task automatic cfg(input logic [7:0] d);
      wr(`OFS_OUTPUT_BEHAVIOUR_CONFIG, d);
      if (!oe_last && d[7]) begin
         logic_reset();
      end
      oe_last = d[7];
   endtask
endmodule

// ---- sim/cfg_rst_regs_tb.sv ----
// Self-checking bench of the config and reset register bank
`timescale 1ns/1ps
module cfg_rst_regs_tb;
   localparam logic [15:0] RST_CYC = 16'h0004;
   localparam int          LIMIT   = 20000;
   logic       clk, rst, lock, rec_clk, osc_clk, wr, rd, lrst, frst, lrst_d;
   logic       oe, uss, act, use_osc, pclk;
   logic [6:0] strap, bus_addr;
   logic [7:0] addr, wdata, rdata, v, d, c;
   logic [1:0] fsel;
   int         errors, n_checks, seed, cyc, lcnt, fcnt, lpulses;

   cfg_host_model #(.WAIT_CYC(40)) u_cfg_host_model (.clk_i(clk), .addr_o(addr),
      .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata));

   cfg_rst_regs #(.LOGIC_RST_CYC(RST_CYC), .FULL_RST_CYC(RST_CYC)) u_cfg_rst_regs (
      .CLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
      .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .ADDRESS_STRAP_PIN_I(strap),
      .LINK_LOCK_I(lock), .RECOVERED_PCLK_I(rec_clk), .OSC_CLK_I(osc_clk),
      .BUS_ADDRESS_O(bus_addr), .CORE_LOGIC_RST_O(lrst), .CORE_FULL_RST_O(frst),
      .OUT_ENABLE_O(oe), .UNLOCKED_STATE_CHOICE_O(uss), .OUTPUTS_ACTIVE_O(act),
      .PCLK_USE_OSC_O(use_osc), .PCLK_O(pclk), .OSC_FREQ_SEL_O(fsel));

   // ****************************************
   // Clock, watchdog and reset pulse counters
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         errors++;
         print_verdict();
      end
   end

   // Soft reset lengths and logic reset pulse count
   always @(negedge clk) begin
      if (lrst) lcnt++;
      if (frst) fcnt++;
      if (lrst && !lrst_d) lpulses++;
      lrst_d <= lrst;
   end

   // ****************************************
   // Checking helpers
   // ****************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Effective enable, sleep select, outputs active and oscillator use
   function automatic logic [3:0] exp_out(input logic [7:0] cf, input logic lk);
      logic o, s;
      o = cf[6] ? cf[7] : 1'b1;
      s = cf[6] ? cf[4] : 1'b1;
      return {o, s, o & (lk | ~s), cf[5] & ~lk};
   endfunction

   // Pulse length within the designer's N to N+1 cycles
   function automatic logic [7:0] len_ok(input int n);
      return {7'h00, (n >= int'(RST_CYC)) && (n <= int'(RST_CYC) + 1)};
   endfunction

   task automatic print_verdict();
      if (errors == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      seed = 34275;
      rst = 1'b1;
      lock = 1'b1;
      rec_clk = 1'b0;
      osc_clk = 1'b1;
      lrst_d = 1'b0;
      strap = 7'($random(seed));
      repeat (16) @(negedge clk);
      rst = 1'b0;
      repeat (6) @(negedge clk);
      u_cfg_host_model.rd(8'h01, d);
      chk(d, 8'h04);
      u_cfg_host_model.rd(8'h02, d);
      chk(d, 8'h80);
      u_cfg_host_model.rd(8'h00, d);
      chk(d, {strap, 1'b0});
      chk({1'b0, bus_addr}, {1'b0, strap});
      // Programmed address on, off, and on again for the retention check
      v = 8'($random(seed)) | 8'h01;
      u_cfg_host_model.wr(8'h00, v);
      @(negedge clk);
      chk({1'b0, bus_addr}, {1'b0, v[7:1]});
      u_cfg_host_model.wr(8'h00, v & 8'hfe);
      @(negedge clk);
      chk({1'b0, bus_addr}, {1'b0, strap});
      u_cfg_host_model.wr(8'h00, v);
      u_cfg_host_model.rd(8'h00, d);
      chk(d, v);
      // All upper config codes against random lock and clock levels
      lcnt = 0;
      lpulses = 0;
      for (int i = 0; i < 16; i++) begin
         c = {4'(i), 4'h0};
         lock = 1'($random(seed));
         rec_clk = 1'($random(seed));
         osc_clk = ~rec_clk;
         u_cfg_host_model.cfg(c);
         repeat (4) @(negedge clk);
         chk({4'h0, oe, uss, act, use_osc}, {4'h0, exp_out(c, lock)});
         chk({7'h00, pclk}, {7'h00, (c[5] & ~lock) ? osc_clk : rec_clk});
         u_cfg_host_model.rd(8'h02, d);
         chk(d, c);
      end
      chk(8'(lpulses), 8'h01);
      chk(len_ok(lcnt), 8'h01);
      u_cfg_host_model.rd(8'h00, d);
      chk(d, v);
      u_cfg_host_model.rd(8'h01, d);
      chk(d & 8'h03, 8'h00);
      // Oscillator frequency field and an unmapped place
      d = 8'($random(seed));
      u_cfg_host_model.wr(8'h24, d);
      @(negedge clk);
      chk({6'h00, fsel}, {6'h00, d[2:1]});
      u_cfg_host_model.wr(8'h30, 8'hff);
      u_cfg_host_model.rd(8'h30, d);
      chk(d, 8'h00);
      // Full reset brings the strap address and config defaults back
      fcnt = 0;
      u_cfg_host_model.full_reset();
      chk(len_ok(fcnt), 8'h01);
      u_cfg_host_model.rd(8'h00, d);
      chk(d, {strap, 1'b0});
      chk({1'b0, bus_addr}, {1'b0, strap});
      u_cfg_host_model.rd(8'h02, d);
      chk(d, 8'h80);
      u_cfg_host_model.rd(8'h01, d);
      chk(d, 8'h04);
      print_verdict();
   end
endmodule
